// ===== acc_pkg.sv
// shared constants for the analog comparator control block
package acc_pkg;

	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int NUM_CH       = 3;
	localparam int ADDR_W       = 8;
	localparam int DATA_W       = 32;
	localparam int SEL_W        = 3;
	localparam int ROUTE_W      = 4;
	localparam int FILT_W       = 5;
	localparam int HIST_LEN     = 32;
	localparam int CNT_W        = 6;
	localparam int DIV_W        = 16;
	localparam int TRIM_W       = 6;
	localparam int HYSTERESIS_LEVEL_W       = 2;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h00;
	localparam logic [7:0] OFS_WINDOW     = 8'h08;
	localparam logic [7:0] OFS_LOCK       = 8'h0c;
	localparam logic [7:0] OFS_CTRL_BASE  = 8'h10;
	localparam logic [7:0] OFS_FILC_BASE  = 8'h14;
	localparam logic [7:0] OFS_FILP_BASE  = 8'h18;
	localparam logic [7:0] OFS_CH_STRIDE  = 8'h10;
	localparam logic [7:0] OFS_REFERENCE  = 8'h40;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h48;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int CTRL_EN      = 0;
	localparam int CTRL_NEG_LSB = 1;
	localparam int CTRL_POS_LSB = 5;
	localparam int CTRL_RTE_LSB = 9;
	localparam int CTRL_POL     = 13;
	localparam int CTRL_HYS_LSB = 14;
	localparam int CTRL_BLK_LSB = 16;
	localparam int CTRL_OUT     = 19;
	localparam int CTRL_FVAL    = 21;
	localparam logic [31:0] CTRL_WMASK = 32'h0007_feef;

	// filter control fields
	localparam int FILC_EN      = 0;
	localparam int FILC_THR_LSB = 1;
	localparam int FILC_WIN_LSB = 6;

	// reference register: per channel enable then trim, 7 bits each
	localparam int REF_STRIDE   = 7;

	// ------------------------------------------------------------
	// selection codes
	// ------------------------------------------------------------
	localparam logic [2:0] POS_FLOAT_ALL  = 3'h7;
	localparam logic [2:0] POS_FLOAT_CH3  = 3'h6;
	localparam logic [2:0] POS_PAIR_CH1   = 3'h6;
	localparam logic [2:0] POS_PAIR_CH2   = 3'h0;
	localparam logic [2:0] NEG_INT_REF    = 3'h0;
	localparam logic [2:0] NEG_FLOAT_5    = 3'h5;
	localparam logic [2:0] NEG_FLOAT_6    = 3'h6;
	localparam logic [2:0] NEG_FLOAT_7    = 3'h7;
	localparam logic [2:0] BLK_NONE       = 3'h0;
	localparam logic [2:0] BLK_TIMER_ONE  = 3'h1;
	localparam logic [2:0] BLK_TIMER_EIGHT = 3'h2;

	localparam logic [3:0] RTE_NONE       = 4'h0;
	localparam logic [3:0] RTE_BRK_ONE    = 4'h1;
	localparam logic [3:0] RTE_NC_5       = 4'h5;
	localparam logic [3:0] RTE_NC_A       = 4'ha;
	localparam logic [3:0] RTE_NC_B       = 4'hb;
	localparam logic [3:0] RTE_NC_C       = 4'hc;
	localparam logic [3:0] RTE_BRK_EIGHT  = 4'hd;
	localparam logic [3:0] RTE_BRK_BOTH   = 4'he;
	localparam logic [3:0] RTE_LP_TRIGGER_ROUTE    = 4'hf;

endpackage

// ===== acc_filter.sv
// sample-window vote filter with its own prescaled sampling enable
`timescale 1ns/1ps
module acc_filter
	import acc_pkg::*;
(
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	// configuration
	input  wire logic              filter_enable,
	input  wire logic [DIV_W-1:0]  filter_clock_divider,
	input  wire logic [FILT_W-1:0] filter_window_length,
	input  wire logic [FILT_W-1:0] filter_vote_threshold,
	// data
	input  wire logic              sample_in,
	output logic                   filt_out
);

	logic [DIV_W-1:0]    div_reg;
	logic                tick;
	logic [HIST_LEN-1:0] hist_reg;
	logic                filt_reg;
	logic [CNT_W-1:0]    ones;
	logic [CNT_W-1:0]    zeros;
	logic [CNT_W-1:0]    win_len;

	// ------------------------------------------------------------
	// sampling enable: one pulse every divider+1 clocks
	// ------------------------------------------------------------
	assign tick = (div_reg == filter_clock_divider);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			div_reg <= '0;
		else if (!filter_enable || tick)
			div_reg <= '0;
		else
			div_reg <= div_reg + 1'b1;
	end

	// ------------------------------------------------------------
	// sample history, newest in bit 0
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			hist_reg <= '0;
		else if (filter_enable && tick)
			hist_reg <= {hist_reg[HIST_LEN-2:0], sample_in};
	end

	// votes inside the window of length+1 samples
	always_comb begin
		ones    = '0;
		win_len = CNT_W'(filter_window_length) + 1'b1;
		for (int i = 0; i < HIST_LEN; i++) begin
			if ((CNT_W'(i) < win_len) && hist_reg[i])
				ones = ones + 1'b1;
		end
		zeros = win_len - ones;
	end

	// when enabled, output moves only on a qualified majority; a weak threshold lets it chatter
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			filt_reg <= 1'b0;
		else if (!filter_enable)
			filt_reg <= sample_in;
		else if (ones >= CNT_W'(filter_vote_threshold))
			filt_reg <= 1'b1;
		else if (zeros >= CNT_W'(filter_vote_threshold))
			filt_reg <= 1'b0;
	end

	assign filt_out = filt_reg;

endmodule // acc_filter

// ===== acc_route.sv
// per-channel decode of the trigger route code
`timescale 1ns/1ps
module acc_route
	import acc_pkg::*;
#(
	parameter int CHAN = 0
)(
	// inputs
	input  wire logic               result,
	input  wire logic [ROUTE_W-1:0] trigger_route,
	// outputs
	output logic                    trigger_route_level,
	output logic                    brk_one,
	output logic                    brk_eight,
	output logic                    lp_trigger_route
);

	logic not_conn;

	// unconnected codes differ per channel
	always_comb begin
		not_conn = (trigger_route == RTE_NONE);
		case (CHAN)
			0: not_conn = not_conn || (trigger_route == RTE_NC_C);
			1: not_conn = not_conn || (trigger_route == RTE_NC_B) ||
				(trigger_route == RTE_NC_C);
			default: not_conn = not_conn || (trigger_route == RTE_NC_5) ||
				(trigger_route == RTE_NC_A);
		endcase
	end

	// break and low-power destinations are shared, so decode them here
	assign trigger_route_level = result && !not_conn;
	assign brk_one    = result && ((trigger_route == RTE_BRK_ONE) ||
		(trigger_route == RTE_BRK_BOTH));
	assign brk_eight  = result && ((trigger_route == RTE_BRK_EIGHT) ||
		(trigger_route == RTE_BRK_BOTH));
	assign lp_trigger_route    = result && (trigger_route == RTE_LP_TRIGGER_ROUTE);

endmodule // acc_route

// ===== acc_top.sv
// digital control of three analog comparators: registers, filter, routing
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module acc_top
	import acc_pkg::*;
(
	// clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    reset_n,
	// register port
	input  wire logic [ADDR_W-1:0]       bus_addr,
	input  wire logic [DATA_W-1:0]       bus_wdata,
	input  wire logic                    bus_write,
	input  wire logic                    bus_read,
	output logic [DATA_W-1:0]            bus_rdata,
	// analog comparator cores
	input  wire logic [NUM_CH-1:0]       comp_raw,
	output logic [NUM_CH-1:0]            comp_enable,
	output logic [NUM_CH*SEL_W-1:0]      positive_input_select,
	output logic [NUM_CH-1:0]            positive_float,
	output logic [NUM_CH*SEL_W-1:0]      negative_input_select,
	output logic [NUM_CH-1:0]            negative_float,
	output logic [NUM_CH-1:0]            negative_internal_ref,
	output logic [NUM_CH*HYSTERESIS_LEVEL_W-1:0]     hysteresis_level,
	output logic [NUM_CH-1:0]            internal_reference_enable,
	output logic [NUM_CH*TRIM_W-1:0]     internal_reference_trim,
	output logic                         pair_window_mode,
	// blanking sources
	input  wire logic                    timer_one_compare5,
	input  wire logic                    timer_eight_compare5,
	// results and triggers
	output logic [NUM_CH-1:0]            comp_out,
	output logic [NUM_CH*ROUTE_W-1:0]    output_route_select,
	output logic [NUM_CH-1:0]            trigger_level,
	output logic                         timer_one_break_input,
	output logic                         timer_eight_break_input,
	output logic                         low_power_timer_ext_trigger,
	// interrupt and wake
	output logic                         comp_irq,
	output logic                         wake_request
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	// software-visible settings and flags, plus the registered output and its previous value
	logic [DATA_W-1:0] ctrl_reg [NUM_CH];
	logic [DATA_W-1:0] filc_reg [NUM_CH];
	logic [DIV_W-1:0]  filp_reg [NUM_CH];
	logic [NUM_CH-1:0] irq_en_reg;
	logic [NUM_CH-1:0] lock_reg;
	logic [NUM_CH-1:0] irq_status_reg;
	logic              window_reg;
	logic [REF_STRIDE*NUM_CH-1:0] ref_reg;
	logic [NUM_CH-1:0] out_reg;
	logic [NUM_CH-1:0] out_prev_reg;
	// read path
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;

	// per-channel nets, bit i is channel i+1
	logic [NUM_CH-1:0] polar;
	logic [NUM_CH-1:0] filt;
	logic [NUM_CH-1:0] blank;
	logic [NUM_CH-1:0] rise;
	logic [NUM_CH-1:0] brk1_v;
	logic [NUM_CH-1:0] brk8_v;
	logic [NUM_CH-1:0] lpt_v;
	logic [NUM_CH-1:0] ctrl_hit;
	logic [NUM_CH-1:0] filc_hit;
	logic [NUM_CH-1:0] filp_hit;

	// ------------------------------------------------------------
	// per-channel datapath
	// ------------------------------------------------------------
	// everything in the loop is one channel's private logic
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			// decoded select codes of this channel
			logic [SEL_W-1:0] pos_code;
			logic [SEL_W-1:0] neg_code;
			logic [2:0]       blk_code;

			// address decode of the three per-channel groups
			assign ctrl_hit[g] = (bus_addr == OFS_CTRL_BASE + 8'(g) * OFS_CH_STRIDE);
			assign filc_hit[g] = (bus_addr == OFS_FILC_BASE + 8'(g) * OFS_CH_STRIDE);
			assign filp_hit[g] = (bus_addr == OFS_FILP_BASE + 8'(g) * OFS_CH_STRIDE);

			// analog controls straight from the control register
			assign comp_enable[g] = ctrl_reg[g][CTRL_EN];
			assign hysteresis_level[g*HYSTERESIS_LEVEL_W +: HYSTERESIS_LEVEL_W] =
				ctrl_reg[g][CTRL_HYS_LSB +: HYSTERESIS_LEVEL_W];
			assign neg_code = ctrl_reg[g][CTRL_NEG_LSB +: SEL_W];
			assign blk_code = ctrl_reg[g][CTRL_BLK_LSB +: 3];
			assign output_route_select[g*ROUTE_W +: ROUTE_W] =
				ctrl_reg[g][CTRL_RTE_LSB +: ROUTE_W];

			// window mode overrides both positive selects onto the shared pin
			always_comb begin
				pos_code = ctrl_reg[g][CTRL_POS_LSB +: SEL_W];
				if (window_reg && g == 0)
					pos_code = POS_PAIR_CH1;
				else if (window_reg && g == 1)
					pos_code = POS_PAIR_CH2;
			end
			// 111 floats everywhere, 110 only on the third channel
			assign positive_input_select[g*SEL_W +: SEL_W] = pos_code;
			assign positive_float[g] = (pos_code == POS_FLOAT_ALL) ||
				(g == 2 && pos_code == POS_FLOAT_CH3);

			// 000 is the own reference; 101 floats on channels 1 and 3
			assign negative_input_select[g*SEL_W +: SEL_W] = neg_code;
			assign negative_internal_ref[g] = (neg_code == NEG_INT_REF);
			assign negative_float[g] = (neg_code == NEG_FLOAT_6) ||
				(neg_code == NEG_FLOAT_7) ||
				(g != 1 && neg_code == NEG_FLOAT_5);

			// 64-step reference per channel
			assign internal_reference_enable[g] = ref_reg[g*REF_STRIDE];
			assign internal_reference_trim[g*TRIM_W +: TRIM_W] =
				ref_reg[g*REF_STRIDE+1 +: TRIM_W];

			// raw result is only meaningful while the core is enabled
			// gating here keeps an inverted, disabled core from raising a flag
			assign polar[g] = ctrl_reg[g][CTRL_EN] &&
				(comp_raw[g] ^ ctrl_reg[g][CTRL_POL]);

			// blanking picks a timer compare-5 level; unused codes never mask
			always_comb begin
				case (blk_code)
					BLK_TIMER_ONE:   blank[g] = timer_one_compare5;
					BLK_TIMER_EIGHT: blank[g] = timer_eight_compare5;
					default:         blank[g] = 1'b0;
				endcase
			end

			// one vote filter per channel, each with its own divider
			acc_filter u_filter (
				.ref_clk               (ref_clk),
				.reset_n               (reset_n),
				.filter_enable         (filc_reg[g][FILC_EN]),
				.filter_clock_divider  (filp_reg[g]),
				.filter_window_length  (filc_reg[g][FILC_WIN_LSB +: FILT_W]),
				.filter_vote_threshold (filc_reg[g][FILC_THR_LSB +: FILT_W]),
				.sample_in             (polar[g]),
				.filt_out              (filt[g])
			);

			// routing sees the registered output, never the raw result
			acc_route #(.CHAN(g)) u_route (
				.result        (out_reg[g]),
				.trigger_route (ctrl_reg[g][CTRL_RTE_LSB +: ROUTE_W]),
				.trigger_route_level    (trigger_level[g]),
				.brk_one       (brk1_v[g]),
				.brk_eight     (brk8_v[g]),
				.lp_trigger_route       (lpt_v[g])
			);
		end
	endgenerate

	// the shared-pin switch follows the register directly
	assign pair_window_mode = window_reg;

	// ------------------------------------------------------------
	// final output stage
	// ------------------------------------------------------------
	// registered so pins and triggers see a glitch-free level
	// masking after the filter keeps blanking out of its history
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			out_reg <= '0;
		else
			out_reg <= filt & ~blank;
	end

	// previous output, used only by the edge detect
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			out_prev_reg <= '0;
		else
			out_prev_reg <= out_reg;
	end

	// pins see the same registered level as the timers
	assign comp_out = out_reg;
	// shared destinations may be driven by any channel at once
	assign timer_one_break_input       = |brk1_v;
	assign timer_eight_break_input     = |brk8_v;
	assign low_power_timer_ext_trigger = |lpt_v;

	// ------------------------------------------------------------
	// interrupt flags
	// ------------------------------------------------------------
	// polarity is already folded in, so a rise covers both cases
	// the flag sets one cycle after the output rises
	assign rise = out_reg & ~out_prev_reg;

	// software clears a flag by writing one to its bit
	// a new rise in the clearing cycle wins over the write-one clear
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			irq_status_reg <= '0;
		else if (bus_write && bus_addr == OFS_IRQ_STATUS)
			irq_status_reg <= (irq_status_reg & ~bus_wdata[NUM_CH-1:0]) | rise;
		else
			irq_status_reg <= irq_status_reg | rise;
	end

	assign comp_irq     = |(irq_status_reg & irq_en_reg);
	// combinational so it works with the block clock gated in deep stop
	// limitation: the flag itself still needs a clock edge to set
	assign wake_request = comp_irq;

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	// interrupt enables, one bit per channel
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			irq_en_reg <= '0;
		else if (bus_write && bus_addr == OFS_IRQ_ENABLE)
			irq_en_reg <= bus_wdata[NUM_CH-1:0];
	end

	// window mode pairs channels 1 and 2 on one pin
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			window_reg <= 1'b0;
		else if (bus_write && bus_addr == OFS_WINDOW)
			window_reg <= bus_wdata[0];
	end

	// lock bits only ever set; nothing but reset clears them
	// a zero written to a set bit leaves it alone
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			lock_reg <= '0;
		else if (bus_write && bus_addr == OFS_LOCK)
			lock_reg <= lock_reg | bus_wdata[NUM_CH-1:0];
	end

	// reference settings are not covered by the lock
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			ref_reg <= '0;
		else if (bus_write && bus_addr == OFS_REFERENCE)
			ref_reg <= bus_wdata[REF_STRIDE*NUM_CH-1:0];
	end

	// control writes are dropped silently while the channel is locked
	// status and reserved bits are masked; reserved bits read back as zero, status bits read back live values
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_CH; i++)
				ctrl_reg[i] <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++)
				if (bus_write && ctrl_hit[i] && !lock_reg[i])
					ctrl_reg[i] <= bus_wdata & CTRL_WMASK;
		end
	end

	// filter settings stay writable; only control is guarded
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				filc_reg[i] <= '0;
				filp_reg[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (bus_write && filc_hit[i])
					filc_reg[i] <= {21'h0, bus_wdata[FILC_WIN_LSB+FILT_W-1:0]};
				if (bus_write && filp_hit[i])
					filp_reg[i] <= bus_wdata[DIV_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// register reads
	// ------------------------------------------------------------
	// per-channel groups first, then the shared registers
	always_comb begin
		rdata_next = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (ctrl_hit[i]) begin
				rdata_next = ctrl_reg[i];
				rdata_next[CTRL_OUT]  = out_reg[i];
				rdata_next[CTRL_FVAL] = filt[i];
			end
			if (filc_hit[i])
				rdata_next = filc_reg[i];
			if (filp_hit[i])
				rdata_next = {16'h0, filp_reg[i]};
		end
		case (bus_addr)
			OFS_IRQ_ENABLE: rdata_next = {29'h0, irq_en_reg};
			OFS_WINDOW:     rdata_next = {31'h0, window_reg};
			OFS_LOCK:       rdata_next = {29'h0, lock_reg};
			OFS_REFERENCE:  rdata_next = {11'h0, ref_reg};
			OFS_IRQ_STATUS: rdata_next = {29'h0, irq_status_reg};
			default:        rdata_next = rdata_next;
		endcase
	end

	// read data stands one cycle after the strobe, zero otherwise
	// zero between reads keeps the idle bus quiet
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			rdata_reg <= '0;
		else if (bus_read)
			rdata_reg <= rdata_next;
		else
			rdata_reg <= '0;
	end

	// read data comes straight from a flip-flop
	assign bus_rdata = rdata_reg;

endmodule // acc_top

// ===== acc_analog_model.sv
// behavioural model of the three analog comparator cores
`timescale 1ns/1ps
module acc_analog_model
	import acc_pkg::*;
(
	// clock
	input  wire logic              ref_clk,
	// core controls from the block
	input  wire logic [NUM_CH-1:0] comp_enable,
	input  wire logic [NUM_CH-1:0] positive_float,
	input  wire logic [NUM_CH-1:0] negative_float,
	// analog condition: positive input above negative input
	input  wire logic [NUM_CH-1:0] above,
	// raw results
	output logic [NUM_CH-1:0]      comp_raw
);
	logic flip = 1'b0;

	// a floating input gives no usable answer, so it chatters every cycle
	always_ff @(posedge ref_clk) begin
		flip <= !flip;
	end

	// high while positive exceeds negative; disabled cores rest low unless an input floats
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (positive_float[i] || negative_float[i]) begin
				comp_raw[i] = flip ^ i[0];
			end else begin
				comp_raw[i] = comp_enable[i] & above[i];
			end
		end
	end
endmodule // acc_analog_model

// ===== acc_top_props.sv
// port-level assertions for the comparator control block
`timescale 1ns/1ps
module acc_top_props
	import acc_pkg::*;
(
	input wire logic                 ref_clk,
	input wire logic                 reset_n,
	input wire logic                 bus_read,
	input wire logic                 bus_write,
	input wire logic [DATA_W-1:0]    bus_rdata,
	input wire logic [NUM_CH-1:0]    comp_out,
	input wire logic [NUM_CH*SEL_W-1:0] positive_input_select,
	input wire logic [NUM_CH-1:0]    positive_float,
	input wire logic [NUM_CH*SEL_W-1:0] negative_input_select,
	input wire logic [NUM_CH-1:0]    negative_internal_ref,
	input wire logic                 pair_window_mode,
	input wire logic [NUM_CH*ROUTE_W-1:0] output_route_select,
	input wire logic [NUM_CH-1:0]    trigger_level,
	input wire logic                 timer_one_break_input,
	input wire logic                 low_power_timer_ext_trigger,
	input wire logic                 comp_irq,
	input wire logic                 wake_request
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// any channel whose output is high and whose route is code a or b
	function automatic logic any_hit(input logic [2:0] o, input logic [11:0] r,
		input logic [3:0] a, input logic [3:0] b);
		any_hit = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (o[i] && (r[4*i+:4] == a || r[4*i+:4] == b)) begin
				any_hit = 1'b1;
			end
		end
	endfunction

	wake_follows_a: assert property (wake_request == comp_irq)
		else $error("wake request differs from interrupt");
	irq_shared_a: assert property ($rose(comp_irq) |-> $past(|comp_out) || $past(bus_write))
		else $error("interrupt rose with no output high and no write");
	window_pin_a: assert property (pair_window_mode |-> positive_input_select[5:0] == 6'h06)
		else $error("window mode positive selects wrong");
	pos_float_a: assert property (positive_float[0] == (positive_input_select[2:0] == 3'h7))
		else $error("channel one float flag wrong");
	ch3_float_a: assert property (positive_float[2] == (positive_input_select[8:7] == 2'h3))
		else $error("channel three float flag wrong");
	neg_ref_a: assert property (negative_internal_ref == {negative_input_select[8:6] == 3'h0,
		negative_input_select[5:3] == 3'h0, negative_input_select[2:0] == 3'h0})
		else $error("internal reference flag wrong");
	brk_one_a: assert property (timer_one_break_input ==
		any_hit(comp_out, output_route_select, 4'h1, 4'he))
		else $error("timer one break wrong");
	lp_trigger_route_a: assert property (low_power_timer_ext_trigger ==
		any_hit(comp_out, output_route_select, 4'hf, 4'hf))
		else $error("low power trigger wrong");
	trigger_route_level_a: assert property (trigger_level[0] == (comp_out[0] &&
		output_route_select[3:0] != 4'h0 && output_route_select[3:0] != 4'hc))
		else $error("trigger level wrong");
	rdata_idle_a: assert property (!$past(bus_read) |-> bus_rdata == 32'h0)
		else $error("read data not zero outside read");
endmodule // acc_top_props

bind acc_top acc_top_props acc_top_props_inst (.ref_clk, .reset_n, .bus_read, .bus_rdata,
	.bus_write, .comp_out, .positive_input_select, .positive_float, .negative_input_select,
	.negative_internal_ref, .pair_window_mode, .output_route_select, .trigger_level,
	.timer_one_break_input, .low_power_timer_ext_trigger, .comp_irq, .wake_request);

// ===== testbench.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module testbench
	import acc_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  bus_addr = 8'h00;
	logic [31:0] bus_wdata = 32'h0;
	logic        bus_write = 1'b0;
	logic        bus_read = 1'b0;
	logic [31:0] bus_rdata;
	logic [2:0]  comp_raw, comp_enable, positive_float, negative_float, negative_internal_ref;
	logic [2:0]  above = 3'h0;
	logic [2:0]  internal_reference_enable, comp_out, trigger_level;
	logic [8:0]  positive_input_select, negative_input_select;
	logic [5:0]  hysteresis_level;
	logic [17:0] internal_reference_trim;
	logic [11:0] output_route_select;
	logic        timer_one_compare5 = 1'b0;
	logic        timer_eight_compare5 = 1'b0;
	logic        pair_window_mode, comp_irq, wake_request;
	logic        timer_one_break_input, timer_eight_break_input, low_power_timer_ext_trigger;
	logic [31:0] d;
	int          errors = 0;
	int          check_count = 0;
	localparam logic [7:0] C0 = OFS_CTRL_BASE;
	localparam logic [7:0] C1 = OFS_CTRL_BASE + OFS_CH_STRIDE;
	localparam logic [7:0] C2 = OFS_CTRL_BASE + 8'h20;

	always #10 ref_clk = !ref_clk;

	acc_top acc_top_inst (.*);
	acc_analog_model acc_analog_model_inst (.ref_clk, .comp_enable, .positive_float,
		.negative_float, .above, .comp_raw);

	// ------------------------------------------------------------
	// bus and compare helpers
	// ------------------------------------------------------------
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		bus_write <= 1'b1;
		bus_addr <= a;
		bus_wdata <= v;
		@(posedge ref_clk);
		bus_write <= 1'b0;
		#1;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		bus_read <= 1'b1;
		bus_addr <= a;
		@(posedge ref_clk);
		bus_read <= 1'b0;
		#1 v = bus_rdata;
	endtask

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task wait_n(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task report_and_stop;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_regs;
		rd(C0, d);
		chk("ctrl reset", d, 32'h0);
		rd(8'h04, d);
		chk("unmapped", d, 32'h0);
		wr(C1, 32'h0000_4002);
		rd(C1, d);
		chk("ctrl2", d & 32'hffff, 32'h4002);
		rd(C0, d);
		chk("ctrl1 untouched", d, 32'h0);
		chk("hysteresis_level", hysteresis_level, 6'h04);
	endtask

	task t_sel;
		wr(OFS_WINDOW, 32'h1);
		chk("window pos", positive_input_select[5:0], 6'h06);
		wr(OFS_WINDOW, 32'h0);
		wr(C1, 32'h0000_c0e0);
		chk("hysteresis_level high", hysteresis_level[3:2], 2'h3);
		chk("pos float", positive_float[1], 1'b1);
		chk("neg ref", negative_internal_ref[1], 1'b1);
		wr(C1, 32'h0000_000c);
		chk("neg float", negative_float[1], 1'b1);
		wr(OFS_REFERENCE, 32'h7f << 7);
		chk("ref en", internal_reference_enable, 3'b010);
		chk("ref trim", internal_reference_trim[11:6], 6'h3f);
		wr(C1, 32'h0);
	endtask

	task t_path;
		above[0] <= 1'b1;
		wr(C0, 32'h0000_0201);
		wr(OFS_IRQ_ENABLE, 32'h1);
		chk("enable", comp_enable, 3'b001);
		wait_n(4);
		chk("out", comp_out[0], 1'b1);
		chk("brk1", timer_one_break_input, 1'b1);
		chk("irq", comp_irq, 1'b1);
		chk("wake", wake_request, 1'b1);
		rd(OFS_IRQ_STATUS, d);
		chk("status", d[2:0], 3'b001);
		wr(OFS_IRQ_STATUS, 32'h1);
		wait_n(1);
		chk("irq clear", comp_irq, 1'b0);
		above[0] <= 1'b0;
		wait_n(4);
		chk("out low", comp_out[0], 1'b0);
	endtask

	task t_pol_blank;
		wr(C1, 32'h0000_2001);
		wait_n(4);
		chk("inverted", comp_out[1], 1'b1);
		above[0] <= 1'b1;
		timer_one_compare5 <= 1'b1;
		wr(C0, 32'h0001_0001);
		wait_n(4);
		chk("blanked", comp_out[0], 1'b0);
		timer_one_compare5 <= 1'b0;
		timer_eight_compare5 <= 1'b1;
		wait_n(4);
		chk("other blank", comp_out[0], 1'b1);
		wr(C0, 32'h0002_0001);
		wait_n(2);
		chk("blank eight", comp_out[0], 1'b0);
		timer_eight_compare5 <= 1'b0;
		wr(C1, 32'h0);
	endtask

	task t_route;
		logic [3:0] codes [6] = '{4'h0, 4'h1, 4'hc, 4'hd, 4'he, 4'hf};
		foreach (codes[i]) begin
			wr(C0, 32'h1 | (32'(codes[i]) << 9));
			chk("brk1", timer_one_break_input, codes[i] == 4'h1 || codes[i] == 4'he);
			chk("brk8", timer_eight_break_input, codes[i] == 4'hd || codes[i] == 4'he);
			chk("lp", low_power_timer_ext_trigger, codes[i] == 4'hf);
			chk("lvl", trigger_level[0], codes[i] != 4'h0 && codes[i] != 4'hc);
		end
	endtask

	task t_filter;
		above[2] <= 1'b1;
		wr(OFS_FILC_BASE + 8'h20, 32'h0000_0107);
		wr(OFS_FILP_BASE + 8'h20, 32'h0);
		wr(C2, 32'h1);
		chk("filt early", comp_out[2], 1'b0);
		wait_n(12);
		chk("filt high", comp_out[2], 1'b1);
		rd(C2, d);
		chk("filtered", d[CTRL_FVAL], 1'b1);
		above[2] <= 1'b0;
		wait_n(2);
		chk("filt hold", comp_out[2], 1'b1);
		wait_n(12);
		chk("filt low", comp_out[2], 1'b0);
	endtask

	task t_lock;
		wr(OFS_LOCK, 32'h4);
		wr(C2, 32'h0000_00a0);
		rd(C2, d);
		chk("locked", d & 32'hffff, 32'h1);
		wr(OFS_LOCK, 32'h0);
		rd(OFS_LOCK, d);
		chk("lock kept", d[2:0], 3'b100);
		wr(C0, 32'h2);
		rd(C0, d);
		chk("open ch1", d & 32'hffff, 32'h2);
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_regs();
		t_sel();
		t_path();
		t_pol_blank();
		t_route();
		t_filter();
		t_lock();
		report_and_stop();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		errors++;
		report_and_stop();
	end
endmodule // testbench
